// ---- src/sadc_ctrl.sv ----
// sequencer, clocking, flags and registers of a four-input converter
`timescale 1ns/1ns
module sadc_ctrl #(
  parameter int NCH = 4,
  parameter int RW  = 10
) (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic [7:0]    addr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [31:0]   rdata_o,
  input  wire logic [2:0]    timer_wave_output_i,
  input  wire logic          external_trigger_pin_i,
  output logic               analog_power_on_o,
  output logic               conv_clk_en_o,
  output logic               sample_o,
  output logic               convert_start_o,
  output logic [1:0]         mux_select_o,
  output logic [NCH-1:0]     analog_inputs_route_o,
  input  wire logic [RW-1:0] cell_result_i,
  output logic               irq_o,
  output logic               dma_req_o,
  output logic               dma_wide_o,
  output logic [15:0]        dma_data_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [31:0] mode_reg;
  logic [NCH-1:0] ch_en_reg;
  logic wr_cmd, wr_mode, rd_stat, rd_latest;
  logic [NCH-1:0] rd_ch;
  assign wr_cmd    = wr_i && addr_i == sadc_pkg::OFF_CMD;
  assign wr_mode   = wr_i && addr_i == sadc_pkg::OFF_MODE;
  assign rd_stat   = rd_i && addr_i == sadc_pkg::OFF_STATUS;
  assign rd_latest = rd_i && addr_i == sadc_pkg::OFF_LATEST;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      rd_ch[i] = rd_i &&
        addr_i == sadc_pkg::OFF_CH_DATA0 + 8'(4 * i);
    end
  end

  logic       hw_trigger_enable, eight_bit_select, sleep_mode;
  logic [2:0] trigger_source_select;
  logic [5:0] clock_divider_setting;
  logic [6:0] startup_setting;
  logic [3:0] sample_hold_cycles;
  assign hw_trigger_enable     = mode_reg[sadc_pkg::MODE_HWEN_BIT];
  assign trigger_source_select = mode_reg[sadc_pkg::MODE_TSEL_LSB +: 3];
  assign eight_bit_select      = mode_reg[sadc_pkg::MODE_EIGHT_BIT];
  assign sleep_mode            = mode_reg[sadc_pkg::MODE_SLEEP_BIT];
  assign clock_divider_setting = mode_reg[sadc_pkg::MODE_DIV_LSB +: 6];
  assign startup_setting       = mode_reg[sadc_pkg::MODE_START_LSB +: 7];
  assign sample_hold_cycles    = mode_reg[sadc_pkg::MODE_SH_LSB +: 4];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_reg <= sadc_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_reg <= wdata_i & 32'h0f7f_ff3f;
    end
  end

  // separate set and clear writes; enable also routes the pin
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ch_en_reg <= '0;
    end else if (wr_i && addr_i == sadc_pkg::OFF_CH_EN) begin
      ch_en_reg <= ch_en_reg | wdata_i[NCH-1:0];
    end else if (wr_i && addr_i == sadc_pkg::OFF_CH_DIS) begin
      ch_en_reg <= ch_en_reg & ~wdata_i[NCH-1:0];
    end
  end
  assign analog_inputs_route_o = ch_en_reg;

  // ----------------------------------------------------------------
  // converter clock enable
  // ----------------------------------------------------------------
  logic [6:0] div_cnt;
  logic       clk_run;
  sadc_pkg::sadc_state_e state;
  // restart the divider per channel so sample-hold spans whole periods
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt <= '0;
    end else if (!clk_run || conv_clk_en_o ||
                 state == sadc_pkg::SQ_PICK) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 7'h01;
    end
  end
  // period 2*(setting+1) master cycles: /2 at 0, /128 at 3f
  assign conv_clk_en_o = clk_run &&
    div_cnt == {clock_divider_setting, 1'b1};

  // ----------------------------------------------------------------
  // triggers
  // ----------------------------------------------------------------
  logic [3:0] trg_s1, trg_s2;
  logic       hw_sel, hw_prev, hw_edge, sw_start;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      trg_s1 <= '0;
      trg_s2 <= '0;
    end else begin
      trg_s1 <= {external_trigger_pin_i, timer_wave_output_i};
      trg_s2 <= trg_s1;
    end
  end
  always_comb begin
    unique case (trigger_source_select)
      sadc_pkg::TSEL_TIMER0: hw_sel = trg_s2[0];
      sadc_pkg::TSEL_TIMER1: hw_sel = trg_s2[1];
      sadc_pkg::TSEL_TIMER2: hw_sel = trg_s2[2];
      sadc_pkg::TSEL_EXT:    hw_sel = trg_s2[3];
      default:               hw_sel = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hw_prev <= 1'b0;
    end else begin
      hw_prev <= hw_sel;
    end
  end
  assign hw_edge  = hw_trigger_enable && hw_sel && !hw_prev;
  assign sw_start = wr_cmd && wdata_i[sadc_pkg::CMD_START_BIT];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [9:0]     cnt;
  logic [1:0]     cur_ch;
  logic [NCH-1:0] pending;
  logic           awake, done_pulse;
  logic [RW-1:0]  result;
  logic           start_req;
  // software start stays live with hardware triggering on
  assign start_req = sw_start || hw_edge;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state      <= sadc_pkg::SQ_IDLE;
      cnt        <= '0;
      cur_ch     <= '0;
      pending    <= '0;
      awake      <= 1'b0;
      done_pulse <= 1'b0;
      result     <= '0;
    end else begin
      done_pulse <= 1'b0;
      unique case (state)
        sadc_pkg::SQ_IDLE: begin
          // sleep mode keeps the cell down between sequences
          awake <= !sleep_mode;
          // triggers outside idle are dropped
          if (start_req) begin
            pending <= ch_en_reg;
            cnt     <= '0;
            if (sleep_mode && !awake) begin
              awake <= 1'b1;
              state <= sadc_pkg::SQ_WAKE;
            end else begin
              state <= sadc_pkg::SQ_PICK;
            end
          end
        end
        sadc_pkg::SQ_WAKE: begin
          // start-up wait (setting+1)*8 converter cycles
          if (conv_clk_en_o) begin
            if (cnt == 10'({startup_setting, 3'h7})) begin
              state <= sadc_pkg::SQ_PICK;
            end else begin
              cnt <= cnt + 10'h001;
            end
          end
        end
        sadc_pkg::SQ_PICK: begin
          cnt <= '0;
          if (pending == '0) begin
            state <= sadc_pkg::SQ_IDLE;
            if (sleep_mode) begin
              awake <= 1'b0;
            end
          end else begin
            for (int i = NCH - 1; i >= 0; i--) begin
              if (pending[i]) begin
                cur_ch <= 2'(i);
              end
            end
            state <= sadc_pkg::SQ_SAMPLE;
          end
        end
        sadc_pkg::SQ_SAMPLE: begin
          if (conv_clk_en_o) begin
            if (cnt == 10'(sample_hold_cycles)) begin
              cnt   <= '0;
              state <= sadc_pkg::SQ_CONVERT;
            end else begin
              cnt <= cnt + 10'h001;
            end
          end
        end
        sadc_pkg::SQ_CONVERT: begin
          if (conv_clk_en_o) begin
            if (cnt == 10'(sadc_pkg::CONV_CYCLES - 1)) begin
              state <= sadc_pkg::SQ_STORE;
            end else begin
              cnt <= cnt + 10'h001;
            end
          end
        end
        sadc_pkg::SQ_STORE: begin
          result     <= cell_result_i;
          done_pulse <= pending[cur_ch] & ch_en_reg[cur_ch];
          pending[cur_ch] <= 1'b0;
          state      <= sadc_pkg::SQ_PICK;
        end
      endcase
    end
  end
  assign clk_run = awake;
  assign analog_power_on_o = awake;
  assign mux_select_o      = cur_ch;
  assign sample_o          = state == sadc_pkg::SQ_SAMPLE;
  assign convert_start_o   = state == sadc_pkg::SQ_CONVERT && cnt == '0 &&
                             conv_clk_en_o;

  // ----------------------------------------------------------------
  // result storage and flags
  // ----------------------------------------------------------------
  logic [RW-1:0]  ch_data [NCH];
  logic [RW-1:0]  latest;
  logic [1:0]     last_ch;
  logic [NCH-1:0] done_flag, ovr_flag, done_set, unread;
  logic           ready_flag, govr_flag;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      done_set[i] = done_pulse && last_ch == 2'(i);
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < NCH; i++) begin
        ch_data[i] <= '0;
      end
      latest  <= '0;
      last_ch <= '0;
    end else if (state == sadc_pkg::SQ_STORE) begin
      ch_data[cur_ch] <= cell_result_i;
      latest          <= cell_result_i;
      last_ch         <= cur_ch;
    end
  end

  // result not yet read through its own channel register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      unread <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (done_set[i]) begin
          unread[i] <= 1'b1;
        end else if (rd_ch[i]) begin
          unread[i] <= 1'b0;
        end
      end
    end
  end

  // set wins over a clearing read in the same cycle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_flag <= '0;
      ovr_flag  <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (done_set[i]) begin
          done_flag[i] <= 1'b1;
        end else if (rd_ch[i] || (rd_latest && last_ch == 2'(i))) begin
          done_flag[i] <= 1'b0;
        end
        if (done_set[i] && unread[i]) begin
          ovr_flag[i] <= 1'b1;
        end else if (rd_stat) begin
          ovr_flag[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_flag <= 1'b0;
      govr_flag  <= 1'b0;
    end else begin
      if (done_pulse) begin
        ready_flag <= 1'b1;
      end else if (rd_latest) begin
        ready_flag <= 1'b0;
      end
      if (done_pulse && ready_flag) begin
        govr_flag <= 1'b1;
      end else if (rd_stat) begin
        govr_flag <= 1'b0;
      end
    end
  end

  assign irq_o = |done_flag || ready_flag;

  // ----------------------------------------------------------------
  // dma request on ready rising, enabled channels only
  // ----------------------------------------------------------------
  logic [RW-1:0] fmt_latest;
  assign fmt_latest = eight_bit_select ?
    {2'b00, latest[RW-3:0]} : latest;
  logic ready_prev;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_prev <= 1'b0;
    end else begin
      ready_prev <= ready_flag;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dma_req_o  <= 1'b0;
      dma_wide_o <= 1'b1;
      dma_data_o <= '0;
    end else begin
      dma_req_o  <= ready_flag && !ready_prev;
      dma_wide_o <= !eight_bit_select;
      dma_data_o <= 16'(fmt_latest);
    end
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= '0;
      if (addr_i == sadc_pkg::OFF_MODE) begin
        rdata_o <= mode_reg;
      end else if (addr_i == sadc_pkg::OFF_CH_STAT) begin
        rdata_o <= 32'(ch_en_reg);
      end else if (rd_stat) begin
        rdata_o <= 32'(done_flag) |
          (32'(ovr_flag) << sadc_pkg::STAT_OVR_LSB) |
          (32'(ready_flag) << sadc_pkg::STAT_RDY_BIT) |
          (32'(govr_flag) << sadc_pkg::STAT_GOVR_BIT);
      end else if (rd_latest) begin
        rdata_o <= 32'(fmt_latest) |
          (32'(last_ch) << sadc_pkg::LATEST_CH_LSB);
      end
      for (int i = 0; i < NCH; i++) begin
        if (rd_ch[i]) begin
          rdata_o <= eight_bit_select ? 32'(ch_data[i][RW-3:0]) :
                     32'(ch_data[i]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sw_start_a: assert property (
    sw_start && state == sadc_pkg::SQ_IDLE |=> state != sadc_pkg::SQ_IDLE)
    else $error("software start not taken");
  ready_set_a: assert property (
    done_pulse |=> ready_flag) else $error("ready flag not set");
  govr_set_a: assert property (
    done_pulse && ready_flag |=> govr_flag) else $error("no global overrun");
  ovr_clear_a: assert property (
    rd_stat && !done_pulse |=> ovr_flag == '0 && !govr_flag)
    else $error("overrun not cleared");
  latest_clr_a: assert property (
    rd_latest && !done_pulse |=> !ready_flag)
    else $error("ready not cleared by read");
  dma_edge_a: assert property (
    $rose(ready_flag) |=> dma_req_o) else $error("dma request missing");
  irq_line_a: assert property (
    ready_flag |-> irq_o) else $error("interrupt not raised");
  conv_len_a: assert property (
    state == sadc_pkg::SQ_CONVERT && cnt == 10'h000 && conv_clk_en_o
    |=> state == sadc_pkg::SQ_CONVERT) else $error("convert too short");
  eight_fmt_a: assert property (
    eight_bit_select |-> fmt_latest[RW-1:RW-2] == 2'b00)
    else $error("upper bits not zero");

  seq_run_c: cover property (state == sadc_pkg::SQ_STORE);
  sleep_c:   cover property (state == sadc_pkg::SQ_WAKE);
  govr_c:    cover property (govr_flag);
  hw_trig_c: cover property (hw_edge && state == sadc_pkg::SQ_IDLE);

endmodule

// ---- src/sadc_pkg.sv ----
// constants for the converter sequencer control block
package sadc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_CH_EN    = 8'h10;
  localparam logic [7:0] OFF_CH_DIS   = 8'h14;
  localparam logic [7:0] OFF_CH_STAT  = 8'h18;
  localparam logic [7:0] OFF_STATUS   = 8'h1c;
  localparam logic [7:0] OFF_LATEST   = 8'h20;
  localparam logic [7:0] OFF_CH_DATA0 = 8'h30;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_START_BIT  = 1;
  localparam int MODE_HWEN_BIT  = 0;
  localparam int MODE_TSEL_LSB  = 1;
  localparam int MODE_EIGHT_BIT = 4;
  localparam int MODE_SLEEP_BIT = 5;
  localparam int MODE_DIV_LSB   = 8;
  localparam int MODE_START_LSB = 16;
  localparam int MODE_SH_LSB    = 24;
  localparam int STAT_OVR_LSB   = 8;
  localparam int STAT_RDY_BIT   = 16;
  localparam int STAT_GOVR_BIT  = 17;
  localparam int LATEST_CH_LSB  = 12;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [2:0]  TSEL_TIMER0 = 3'h0;
  localparam logic [2:0]  TSEL_TIMER1 = 3'h1;
  localparam logic [2:0]  TSEL_TIMER2 = 3'h2;
  localparam logic [2:0]  TSEL_EXT    = 3'h6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CONV_CYCLES    = 10;
  localparam int STARTUP_FACTOR = 8;

  typedef enum logic [2:0] {
    SQ_IDLE, SQ_WAKE, SQ_PICK, SQ_SAMPLE, SQ_CONVERT, SQ_STORE
  } sadc_state_e;

endpackage

// ---- bench/sadc_cell_model.sv ----
// behavioural analog converter cell with input multiplexer
`timescale 1ns/1ns
module sadc_cell_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       power_i,
  input  wire logic       start_i,
  input  wire logic [1:0] mux_i,
  output logic      [9:0] result_o
);
  logic       start_q;
  logic [7:0] cnt;

  // ------------------------------------------------------------------
  // result latched at conversion start, held through the conversion
  // ------------------------------------------------------------------
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_q  <= 1'b0;
      cnt      <= 8'h5a;
      result_o <= 10'h155;
    end else begin
      start_q <= start_i;
      if (!power_i) begin
        // unpowered cell gives nothing stable
        result_o <= ~result_o;
      end else if (start_i && !start_q) begin
        result_o <= {mux_i, cnt};
        cnt      <= cnt + 8'h01;
      end
    end
  end
endmodule

// ---- bench/sadc_ctrl_tb.sv ----
// self-checking bench for the converter sequencer control
`timescale 1ns/1ns
module sadc_ctrl_tb;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  tmr = 3'h0;
  logic        ext = 1'b0;
  logic [31:0] rdata;
  logic [31:0] st;
  logic        pwr, cke, smp, cst, irq, dreq, dwide;
  logic [1:0]  mux;
  logic [3:0]  route;
  logic [9:0]  cres;
  logic [15:0] ddata;
  logic [7:0]  nk = 8'h5a;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          dma_cnt = 0;
  int          smp_len = 0;
  int          smp_run = 0;
  int          gap = 0;
  int          gap_run = 0;

  always #2 clk = ~clk;

  sadc_ctrl i_sadc_ctrl (
    .core_clk_i(clk), .reset_i(rst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timer_wave_output_i(tmr),
    .external_trigger_pin_i(ext), .analog_power_on_o(pwr),
    .conv_clk_en_o(cke), .sample_o(smp), .convert_start_o(cst),
    .mux_select_o(mux), .analog_inputs_route_o(route),
    .cell_result_i(cres), .irq_o(irq), .dma_req_o(dreq),
    .dma_wide_o(dwide), .dma_data_o(ddata));

  sadc_cell_model i_sadc_cell_model (
    .clk_i(clk), .reset_i(rst), .power_i(pwr), .start_i(cst),
    .mux_i(mux), .result_o(cres));

  // ------------------------------------------------------------------
  // monitors: dma pulses, sample length, converter clock spacing
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (dreq === 1'b1) dma_cnt++;
    if (smp === 1'b1) begin
      smp_run++;
    end else if (smp_run != 0) begin
      smp_len = smp_run;
      smp_run = 0;
    end
    gap_run++;
    if (cke === 1'b1) begin
      gap = gap_run;
      gap_run = 0;
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task stop_test;
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, exp, m, input string s);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, m, input string s);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, e, m, s);
  endtask

  // t of 3 means the external pin
  task pulse(input int t);
    @(posedge clk);
    if (t == 3) ext <= 1'b1;
    else tmr[t] <= 1'b1;
    repeat (4) @(posedge clk);
    ext <= 1'b0;
    tmr <= 3'h0;
  endtask

  // waits for channels 0 and 2, then checks results and clears
  task seq_done(input logic [31:0] es, input logic eight);
    logic [31:0] m;
    logic [31:0] e;
    int n;
    m = eight ? 32'hffff_ff00 : ALL;
    e = {18'h0, 2'd2, 2'd0, 2'd2, nk + 8'h01};
    if (eight) e[9:8] = 2'd0;
    n = 0;
    st = 32'h0;
    while (st[3:0] !== 4'h5 && n < 300) begin
      rd_reg(sadc_pkg::OFF_STATUS, st);
      n++;
    end
    chk(st, es, ALL, "status");
    chk({31'h0, irq}, 32'h1, ALL, "irq set");
    chk({31'h0, dwide}, {31'h0, !eight}, ALL, "dma width");
    chk({16'h0, ddata}, {16'h0, e[15:0] & 16'h03ff}, m, "dma");
    rchk(sadc_pkg::OFF_CH_DATA0, {24'h0, nk}, m, "ch0");
    rchk(sadc_pkg::OFF_STATUS, 32'h0001_0004, ALL, "st");
    rchk(sadc_pkg::OFF_LATEST, e, m, "latest");
    rchk(sadc_pkg::OFF_STATUS, 32'h0, ALL, "cleared");
    chk({31'h0, irq}, 32'h0, ALL, "irq clear");
    nk = nk + 8'h02;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk(sadc_pkg::OFF_MODE, sadc_pkg::MODE_RESET, ALL, "mode");
    rchk(sadc_pkg::OFF_STATUS, 32'h0, ALL, "reset st");
    rchk(8'h08, 32'h0, ALL, "unmapped");
    chk({31'h0, dwide}, 32'h1, ALL, "reset width");
    wr_reg(sadc_pkg::OFF_CH_EN, 32'hf);
    wr_reg(sadc_pkg::OFF_CH_DIS, 32'ha);
    rchk(sadc_pkg::OFF_CH_STAT, 32'h5, ALL, "chan en");
    chk({28'h0, route}, 32'h5, ALL, "route");
    wr_reg(sadc_pkg::OFF_CMD, 32'h0);
    repeat (100) @(posedge clk);
    rchk(sadc_pkg::OFF_STATUS, 32'h0, ALL, "start zero");
    wr_reg(sadc_pkg::OFF_CMD, 32'h2);
    seq_done(32'h0003_0005, 1'b0);
    chk({31'h0, dma_cnt != 0}, 32'h1, ALL, "dma req");
    wr_reg(sadc_pkg::OFF_MODE, 32'h0000_001d);
    pulse(3);
    seq_done(32'h0003_0405, 1'b1);
    rchk(sadc_pkg::OFF_CH_DATA0 + 8'h08, 32'h0, 32'hffff_ff00, "ch2");
    wr_reg(sadc_pkg::OFF_MODE, 32'h0000_000c);
    pulse(3);
    repeat (100) @(posedge clk);
    rchk(sadc_pkg::OFF_STATUS, 32'h0, ALL, "hw off");
    for (int t = 0; t < 3; t++) begin
      wr_reg(sadc_pkg::OFF_MODE, 32'h1 | (t << 1) |
             ((t == 2) ? 32'h0300_0100 : 32'h0));
      pulse(t);
      seq_done((t == 0) ? 32'h0003_0005 : 32'h0003_0405, 1'b0);
    end
    chk(smp_len, 32'd16, ALL, "sample len");
    chk(gap, 32'd4, ALL, "clk gap");
    wr_reg(sadc_pkg::OFF_CMD, 32'h2);
    seq_done(32'h0003_0405, 1'b0);
    wr_reg(sadc_pkg::OFF_MODE, 32'h0000_0020);
    repeat (20) @(posedge clk);
    chk({31'h0, pwr}, 32'h0, ALL, "sleep off");
    wr_reg(sadc_pkg::OFF_CMD, 32'h2);
    wr_reg(sadc_pkg::OFF_CMD, 32'h2);
    chk({31'h0, pwr}, 32'h1, ALL, "wake");
    seq_done(32'h0003_0405, 1'b0);
    repeat (200) @(posedge clk);
    rchk(sadc_pkg::OFF_STATUS, 32'h0, ALL, "no retrigger");
    chk({31'h0, pwr}, 32'h0, ALL, "sleep again");
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule
